/* File: hdl/aif_pkg.sv */
// Purpose: Shared constants and types for the audio input register bank
// Assumes: Byte wide register port, byte offsets as addresses
// Notes: One clock, asynchronous active low reset
package aif_pkg;

  // ********************************************
  // Register addresses
  // ********************************************
  localparam logic [11:0] ADDR_CNT_LO = 12'hb28;
  localparam logic [11:0] ADDR_CNT_HI = 12'hb29;
  localparam logic [11:0] ADDR_FILL = 12'hb2c;
  localparam logic [11:0] ADDR_MAN_B0 = 12'hb30;
  localparam logic [11:0] ADDR_MAN_B1 = 12'hb31;
  localparam logic [11:0] ADDR_MAN_B2 = 12'hb32;
  localparam logic [11:0] ADDR_MAN_B3 = 12'hb33;
  localparam logic [11:0] ADDR_PATH = 12'hb35;
  localparam logic [11:0] ADDR_CAL_MUL = 12'hb36;
  localparam logic [11:0] ADDR_CAL_BIAS = 12'hb37;
  localparam logic [11:0] ADDR_FILT = 12'hb40;
  localparam logic [11:0] ADDR_LVL_L = 12'hb41;
  localparam logic [11:0] ADDR_LVL_R = 12'hb42;
  localparam logic [11:0] ADDR_LIMIT = 12'hb43;

  // ********************************************
  // Reset values and widths
  // ********************************************
  localparam logic [7:0] FILL_RST = 8'h00;
  localparam logic [7:0] MAN_RST = 8'h00;
  localparam logic [7:0] PATH_RST = 8'h09;
  localparam logic [7:0] CAL_RST = 8'h00;
  localparam logic [7:0] FILT_RST = 8'hfb;
  localparam logic [7:0] LVL_RST = 8'h20;
  localparam logic [7:0] LIMIT_RST = 8'h33;
  localparam logic [6:0] GAIN_RST = 7'h00;
  localparam logic [6:0] GAIN_STEP = 7'h01;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam int NUM_CH = 2;
  localparam int BYTES_PER_WORD = 4;

  // ********************************************
  // Field layouts
  // ********************************************
  typedef struct packed {
    logic [2:0] rsvd;
    logic swap_lr;
    logic trim_bypass;
    logic sign_sel;
    logic ratio_opt;
    logic valid_sel;
  } aif_path_cfg_t;

  typedef struct packed {
    logic dbl_down;
    logic lpf_bypass;
    logic alc_bypass;
    logic hpf_bypass;
    logic [3:0] hpf_adjust;
  } aif_filt_ctl_t;

  typedef struct packed {
    logic auto_mode;
    logic [6:0] val;
  } aif_level_t;

  typedef struct packed {
    logic [15:0] right;
    logic [15:0] left;
  } aif_stereo_t;

  typedef enum logic [0:0] {
    FILL_AUTO = 1'b0,
    FILL_MANUAL = 1'b1
  } aif_fill_t;

endpackage

/* File: hdl/aif_regs.sv */
// Purpose: Register bank and small datapath for the audio input path
// Assumes: Every input, register port included, comes from core_clk logic
// Notes: Gain tracking steps by one per request in automatic mode
//
// Contract
// - Third FIFO fill count readable, low/high byte
// - Fill mode bit 0 picks auto or manual
// - Manual word written as four byte registers
// - Path config bit 4 swaps left and right
// - Path config bits 3..0 trim and converter options
// - Filter control bits 3..0 adjust high-pass output
// - Filter control bit 4 bypasses high-pass
// - Filter control bit 5 bypasses level control
// - Filter control bit 6 bypasses low-pass
// - Filter control bit 7 enables double downsampling
// - Level bit 7 selects automatic or manual gain
// - Manual gain taken from level bits 5..0
// - Automatic gain never below level bits 6..0; the code holds it at the limit when the limit is lower
// - Automatic gain never above limit, reset 0x33
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module aif_regs
  import aif_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // FIFO side
  input wire logic [15:0] fifo2_count,
  input wire logic samp_valid,
  input wire aif_stereo_t samp_in,
  output logic fifo_wr_q,
  output logic [31:0] fifo_wdata_q,
  // Level control requests, one bit per channel
  input wire logic [NUM_CH-1:0] gain_up_req,
  input wire logic [NUM_CH-1:0] gain_dn_req,
  // Configuration and state
  output aif_fill_t fill_mode_q,
  output aif_path_cfg_t path_cfg_q,
  output logic [7:0] cal_mul_q,
  output logic [7:0] cal_bias_q,
  output aif_filt_ctl_t filt_ctl_q,
  output logic [NUM_CH-1:0][6:0] gain_q
);

  // ********************************************
  // Address decode
  // ********************************************
  wire wr_fill = reg_wr && (reg_addr == ADDR_FILL);
  wire wr_path = reg_wr && (reg_addr == ADDR_PATH);
  wire wr_mul = reg_wr && (reg_addr == ADDR_CAL_MUL);
  wire wr_bias = reg_wr && (reg_addr == ADDR_CAL_BIAS);
  wire wr_filt = reg_wr && (reg_addr == ADDR_FILT);
  wire wr_limit = reg_wr && (reg_addr == ADDR_LIMIT);
  wire [11:0] man_base = ADDR_MAN_B0;
  wire [11:0] lvl_base = ADDR_LVL_L;

  logic [BYTES_PER_WORD-1:0] wr_man;
  logic [NUM_CH-1:0] wr_lvl;
  logic [BYTES_PER_WORD-1:0][7:0] man_byte_q;
  aif_level_t [NUM_CH-1:0] level_q;
  logic [6:0] limit_q;

  for (genvar b = 0; b < BYTES_PER_WORD; b++) begin : g_man
    assign wr_man[b] = reg_wr &&
      (reg_addr == man_base + 12'(b));
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        man_byte_q[b] <= MAN_RST;
      end else if (wr_man[b]) begin
        man_byte_q[b] <= reg_wdata;
      end
    end
  end

  // ********************************************
  // Read path
  // ********************************************
  // Count bytes are read live; software reading both bytes of a
  // moving count may see them from different cycles.
  logic [7:0] rd_sel;
  always_comb begin
    rd_sel = RD_NONE;
    unique case (reg_addr)
      ADDR_CNT_LO: rd_sel = fifo2_count[7:0];
      ADDR_CNT_HI: rd_sel = fifo2_count[15:8];
      ADDR_FILL: rd_sel = {7'h00, fill_mode_q};
      ADDR_PATH: rd_sel = path_cfg_q;
      ADDR_CAL_MUL: rd_sel = cal_mul_q;
      ADDR_CAL_BIAS: rd_sel = cal_bias_q;
      ADDR_FILT: rd_sel = filt_ctl_q;
      ADDR_LVL_L: rd_sel = level_q[0];
      ADDR_LVL_R: rd_sel = level_q[1];
      ADDR_LIMIT: rd_sel = {1'b0, limit_q};
      default: rd_sel = RD_NONE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= RD_NONE;
    end else begin
      reg_rdata_q <= reg_rd ? rd_sel : RD_NONE;
    end
  end

  // ********************************************
  // Configuration registers
  // ********************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_mode_q <= aif_fill_t'(FILL_RST[0]);
      path_cfg_q <= PATH_RST;
      cal_mul_q <= CAL_RST;
      cal_bias_q <= CAL_RST;
      filt_ctl_q <= FILT_RST;
      limit_q <= LIMIT_RST[6:0];
    end else begin
      if (wr_fill) begin
        fill_mode_q <= aif_fill_t'(reg_wdata[0]);
      end
      if (wr_path) begin
        path_cfg_q <= {3'b000, reg_wdata[4:0]};
      end
      if (wr_mul) begin
        cal_mul_q <= reg_wdata;
      end
      if (wr_bias) begin
        cal_bias_q <= reg_wdata;
      end
      if (wr_filt) begin
        filt_ctl_q <= reg_wdata;
      end
      if (wr_limit) begin
        limit_q <= reg_wdata[6:0];
      end
    end
  end

  // ********************************************
  // FIFO fill source
  // ********************************************
  // Swap acts only on the sampled stream; the manual word enters
  // the FIFO in its written byte order.
  wire swap = path_cfg_q.swap_lr;
  wire [15:0] first_ch = swap ? samp_in.right : samp_in.left;
  wire [15:0] second_ch = swap ? samp_in.left : samp_in.right;
  wire [31:0] auto_word = {second_ch, first_ch};
  wire [31:0] man_word = {reg_wdata, man_byte_q[2],
                          man_byte_q[1], man_byte_q[0]};
  wire man_sel = (fill_mode_q == FILL_MANUAL);
  wire man_push = man_sel && wr_man[BYTES_PER_WORD-1];
  wire auto_push = !man_sel && samp_valid;
  wire fifo_push = man_push || auto_push;
  wire [31:0] push_word = man_sel ? man_word : auto_word;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_wr_q <= 1'b0;
      fifo_wdata_q <= 32'h0000_0000;
    end else begin
      fifo_wr_q <= fifo_push;
      if (fifo_push) begin
        fifo_wdata_q <= push_word;
      end
    end
  end

  // ********************************************
  // Per channel level and gain
  // ********************************************
  // When the floor is set above the ceiling the ceiling wins, so
  // the amplifier is never driven past its limit in automatic mode.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire [6:0] gmin = level_q[c].val;
    wire [6:0] cur = gain_q[c];
    wire up = gain_up_req[c] && !gain_dn_req[c];
    wire dn = gain_dn_req[c] && !gain_up_req[c];
    wire [6:0] stepped = (up && cur < limit_q) ? cur + GAIN_STEP :
                         (dn && cur > gmin) ? cur - GAIN_STEP : cur;
    wire [6:0] floored = (stepped < gmin) ? gmin : stepped;
    wire [6:0] ceiled = (floored > limit_q) ? limit_q
                        : floored;
    wire [6:0] manual_gain = {1'b0, level_q[c].val[5:0]};
    wire [6:0] gain_d = level_q[c].auto_mode ? ceiled
                        : manual_gain;

    assign wr_lvl[c] = reg_wr && (reg_addr == lvl_base + 12'(c));

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        level_q[c] <= LVL_RST;
        gain_q[c] <= GAIN_RST;
      end else begin
        if (wr_lvl[c]) begin
          level_q[c] <= reg_wdata;
        end
        gain_q[c] <= gain_d;
      end
    end

    a_level_write: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      wr_lvl[c] |=> level_q[c] == $past(reg_wdata))
      else $error("level setting not stored");

    // Helper: level and limit held steady into the next cycle
    wire steady = !wr_lvl[c] && !wr_limit;

    a_gain_manual: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (rst_n && !level_q[c].auto_mode) |=>
        gain_q[c] == {1'b0, $past(level_q[c].val[5:0])})
      else $error("manual gain not taken from level");

    a_gain_floor: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (level_q[c].auto_mode && steady && gmin <= limit_q)
        |=> gain_q[c] >= $past(gmin))
      else $error("automatic gain below floor");

    a_gain_ceiling: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (level_q[c].auto_mode && steady) |=>
        gain_q[c] <= $past(limit_q))
      else $error("automatic gain above ceiling");

    a_gain_step_up: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (level_q[c].auto_mode && steady && up &&
       cur >= gmin && cur < limit_q) |=>
        gain_q[c] == $past(cur) + GAIN_STEP)
      else $error("automatic gain did not step up");
  end

  // ********************************************
  // Checks
  // ********************************************
  sequence s_rd_at(logic [11:0] a);
    reg_rd && reg_addr == a;
  endsequence

  sequence s_man_word;
    man_sel && wr_man[0] ##1
      (man_sel && wr_man[BYTES_PER_WORD-1] && !wr_fill);
  endsequence

  a_count_low: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_CNT_LO) |=>
      reg_rdata_q == $past(fifo2_count[7:0]))
    else $error("count low byte wrong");

  a_count_high: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_CNT_HI) |=>
      reg_rdata_q == $past(fifo2_count[15:8]))
    else $error("count high byte wrong");

  a_rdata_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata_q == RD_NONE)
    else $error("read data outside read answer");

  a_manual_commit: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (man_sel && wr_man[BYTES_PER_WORD-1]) |=>
      fifo_wr_q && fifo_wdata_q[31:24] == $past(reg_wdata))
    else $error("manual word not committed");

  a_manual_word: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_man_word |=>
      fifo_wdata_q[7:0] == $past(reg_wdata, 2))
    else $error("manual low byte lost");

  a_auto_blocks_man: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!man_sel && !samp_valid) |=> !fifo_wr_q)
    else $error("manual write pushed in auto mode");

  a_man_blocks_auto: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (man_sel && !wr_man[BYTES_PER_WORD-1]) |=> !fifo_wr_q)
    else $error("sample pushed in manual mode");

  a_swap_order: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!man_sel && samp_valid && swap) |=>
      fifo_wdata_q == $past({samp_in.left, samp_in.right}))
    else $error("swapped word order wrong");

  a_plain_order: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!man_sel && samp_valid && !swap) |=>
      fifo_wdata_q == $past({samp_in.right, samp_in.left}))
    else $error("unswapped word order wrong");

  a_path_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_path |=> path_cfg_q[4:0] == $past(reg_wdata[4:0])
      && path_cfg_q.rsvd == 3'b000)
    else $error("path config not stored");

  a_filt_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_filt ##1 !wr_filt |->
      filt_ctl_q == $past(reg_wdata))
    else $error("filter control not held");

  a_filt_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_FILT) |=> reg_rdata_q == $past(filt_ctl_q))
    else $error("filter control readback wrong");

  a_limit_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_LIMIT) |=>
      reg_rdata_q == {1'b0, $past(limit_q)})
    else $error("limit readback wrong");

  a_man_unread: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_MAN_B3) |=> reg_rdata_q == RD_NONE)
    else $error("write-only byte read back");

  a_fill_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_fill |=> fill_mode_q == aif_fill_t'($past(reg_wdata[0])))
    else $error("fill mode not stored");

  a_fill_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_FILL) |=>
      reg_rdata_q == {7'h00, $past(fill_mode_q)})
    else $error("fill mode readback wrong");

  a_path_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_PATH) |=> reg_rdata_q == $past(path_cfg_q))
    else $error("path config readback wrong");

  a_mul_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_mul |=> cal_mul_q == $past(reg_wdata))
    else $error("calibration multiplier not stored");

  a_bias_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_bias |=> cal_bias_q == $past(reg_wdata))
    else $error("calibration bias not stored");

  a_limit_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_limit |=> limit_q == $past(reg_wdata[6:0]))
    else $error("gain limit not stored");

  a_level_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_at(ADDR_LVL_L) |=> reg_rdata_q == $past(level_q[0]))
    else $error("left level readback wrong");

  // The FIFO may sample its word late, so it must not move between
  // pushes.
  a_word_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !fifo_push |=> $stable(fifo_wdata_q))
    else $error("FIFO word changed without push");

endmodule

/* File: testbench/aif_regs_tb_top.sv */
// Purpose: Self-checking bench for the audio input register bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Table loop first, then manual word, stream, gain and reset tests
`timescale 1ns/100ps
module aif_regs_tb_top;
  import aif_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } aif_row_t;
  logic core_clk, rst_n, reg_wr, reg_rd, samp_valid, fifo_wr_q;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, cal_mul_q, cal_bias_q, rd_v;
  logic [15:0] fifo2_count;
  logic [31:0] fifo_wdata_q;
  logic [NUM_CH-1:0] gain_up_req, gain_dn_req;
  logic [NUM_CH-1:0][6:0] gain_q;
  aif_stereo_t samp_in;
  aif_fill_t fill_mode_q;
  aif_path_cfg_t path_cfg_q;
  aif_filt_ctl_t filt_ctl_q;
  int err_total, n_checks;
  aif_row_t rows [11];
  aif_row_t rst_rows [7];

  aif_regs dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .fifo2_count(fifo2_count),
    .samp_valid(samp_valid), .samp_in(samp_in), .fifo_wr_q(fifo_wr_q),
    .fifo_wdata_q(fifo_wdata_q), .gain_up_req(gain_up_req),
    .gain_dn_req(gain_dn_req), .fill_mode_q(fill_mode_q),
    .path_cfg_q(path_cfg_q), .cal_mul_q(cal_mul_q), .cal_bias_q(cal_bias_q),
    .filt_ctl_q(filt_ctl_q), .gain_q(gain_q));

  // ****************************************
  // Clock, bus tasks and checks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata_q;
  endtask

  // Push a stereo sample and look at the push in the following cycle
  task automatic samp(input logic [31:0] v, input logic [31:0] exp);
    @(posedge core_clk);
    samp_valid <= 1'b1;
    samp_in <= v;
    @(posedge core_clk);
    samp_valid <= 1'b0;
    #1;
    chk(fifo_wr_q, 32'h0000_0001);
    chk(fifo_wdata_q, exp);
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is about 130 cycles; over twenty times that is a hang
  initial begin
    #(3000 * 100);
    err_total++;
    final_report();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_total = 0;
    n_checks = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    samp_valid = 1'b0;
    samp_in = 32'h0000_0000;
    fifo2_count = 16'h1234;
    gain_up_req = 2'b00;
    gain_dn_req = 2'b00;
    rows = '{'{ADDR_FILL, 8'hff, 8'h01}, '{ADDR_PATH, 8'hff, 8'h1f},
      '{ADDR_CAL_MUL, 8'ha5, 8'ha5}, '{ADDR_CAL_BIAS, 8'h5a, 8'h5a},
      '{ADDR_FILT, 8'ha5, 8'ha5}, '{ADDR_FILT, 8'h5a, 8'h5a},
      '{ADDR_LIMIT, 8'hff, 8'h7f}, '{ADDR_MAN_B0, 8'h11, 8'h00},
      '{12'hb34, 8'hff, 8'h00}, '{ADDR_CNT_LO, 8'hff, 8'h34},
      '{ADDR_CNT_HI, 8'hff, 8'h12}};
    rst_rows = '{'{ADDR_FILL, 8'h00, 8'h00}, '{ADDR_PATH, 8'h00, 8'h09},
      '{ADDR_FILT, 8'h00, 8'hfb}, '{ADDR_LVL_L, 8'h00, 8'h20},
      '{ADDR_LVL_R, 8'h00, 8'h20}, '{ADDR_LIMIT, 8'h00, 8'h33},
      '{ADDR_CAL_MUL, 8'h00, 8'h00}};
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rd_v);
      chk(rd_v, rows[i].e);
      if (rows[i].a == ADDR_FILT) begin
        chk(filt_ctl_q, rows[i].e);
      end
      if (rows[i].a == ADDR_PATH) begin
        chk(path_cfg_q, rows[i].e);
      end
      if (rows[i].a == ADDR_FILL) begin
        chk(fill_mode_q, rows[i].e);
      end
      if (rows[i].a == ADDR_CAL_MUL) begin
        chk(cal_mul_q, rows[i].e);
      end
      if (rows[i].a == ADDR_CAL_BIAS) begin
        chk(cal_bias_q, rows[i].e);
      end
    end
    $display("table test done");
    // Manual word: byte0 is still stored from the table
    wr(ADDR_MAN_B1, 8'h22);
    wr(ADDR_MAN_B2, 8'h33);
    #1;
    chk(fifo_wr_q, 32'h0000_0000);
    wr(ADDR_MAN_B3, 8'h44);
    #1;
    chk(fifo_wr_q, 32'h0000_0001);
    chk(fifo_wdata_q, 32'h4433_2211);
    // Low byte and top byte back to back, no idle cycle between
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_MAN_B0;
    reg_wdata <= 8'h66;
    @(posedge core_clk);
    reg_addr <= ADDR_MAN_B3;
    reg_wdata <= 8'h77;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
    chk(fifo_wdata_q, 32'h7733_2266);
    @(posedge core_clk);
    samp_valid <= 1'b1;
    @(posedge core_clk);
    samp_valid <= 1'b0;
    #1;
    chk(fifo_wr_q, 32'h0000_0000);
    $display("manual word test done");
    wr(ADDR_FILL, 8'h00);
    wr(ADDR_PATH, 8'h00);
    samp(32'hbbbb_aaaa, 32'hbbbb_aaaa);
    wr(ADDR_PATH, 8'h10);
    samp(32'hbbbb_aaaa, 32'haaaa_bbbb);
    wr(ADDR_MAN_B3, 8'h55);
    fifo2_count <= 16'hbeef;
    #1;
    chk(fifo_wr_q, 32'h0000_0000);
    rd(ADDR_CNT_HI, rd_v);
    chk(rd_v, 32'h0000_00be);
    $display("stream test done");
    wr(ADDR_LVL_L, 8'h7f);
    wr(ADDR_LVL_R, 8'h05);
    #1;
    chk(gain_q[0], 32'h0000_003f);
    @(posedge core_clk);
    #1;
    chk(gain_q[1], 32'h0000_0005);
    wr(ADDR_LIMIT, 8'h08);
    wr(ADDR_LVL_L, 8'h85);
    gain_up_req <= 2'b01;
    repeat (12) @(posedge core_clk);
    #1;
    chk(gain_q[0], 32'h0000_0008);
    @(posedge core_clk);
    gain_up_req <= 2'b00;
    gain_dn_req <= 2'b01;
    repeat (12) @(posedge core_clk);
    #1;
    chk(gain_q[0], 32'h0000_0005);
    @(posedge core_clk);
    gain_dn_req <= 2'b00;
    gain_up_req <= 2'b01;
    repeat (2) @(posedge core_clk);
    #1;
    chk(gain_q[0], 32'h0000_0007);
    $display("gain test done");
    // Second reset in mid-run restores every register
    @(posedge core_clk);
    gain_up_req <= 2'b00;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(fifo_wr_q, 32'h0000_0000);
    chk(gain_q[0], 32'h0000_0000);
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(gain_q[0], 32'h0000_0020);
    foreach (rst_rows[i]) begin
      rd(rst_rows[i].a, rd_v);
      chk(rd_v, rst_rows[i].e);
    end
    $display("reset test done");
    final_report();
  end
endmodule
